// *** hw/power_loss_pkg.sv ***
// constants for the power loss recovery controller
package power_loss_pkg;
  localparam int unsigned CLK_HZ        = 125000000;
  localparam int unsigned WINDOW_S      = 30;
  localparam longint unsigned WINDOW_CYC = longint'(WINDOW_S) * longint'(CLK_HZ);
  localparam int unsigned FILTER_CYC    = 4;
  localparam int unsigned BTN_HOLD_CYC  = 2;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ    = 8'h08;
  localparam logic [7:0] OFF_MASK   = 8'h0c;

  // ctrl fields
  localparam int unsigned CTRL_MODE_LSB  = 0;
  localparam int unsigned CTRL_RUN_BIT   = 2;
  localparam int unsigned CTRL_LAST_BIT  = 3;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0004;

  // status fields
  localparam int unsigned ST_SBY_BIT     = 0;
  localparam int unsigned ST_GOOD_BIT    = 1;
  localparam int unsigned ST_ON_BIT      = 2;
  localparam int unsigned ST_MON_BIT     = 3;
  localparam int unsigned ST_LOSS_BIT    = 4;

  // interrupt event bits
  localparam int unsigned EV_ORDERLY     = 0;
  localparam int unsigned EV_LOSS        = 1;
  localparam int unsigned EV_RESTORE     = 2;
  localparam int unsigned EV_BUTTON      = 3;
  localparam int unsigned EV_W           = 4;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    MODE_TURN_ON,
    MODE_REMAIN_OFF,
    MODE_LAST_STATE
  } mode_e;

  typedef enum logic [1:0] {
    PS_ON,
    PS_WATCH,
    PS_OFF,
    PS_LOST
  } pwr_state_e;
endpackage : power_loss_pkg

// *** hw/power_loss_recovery_control.sv ***
// power loss recovery controller with axi4-lite registers
`timescale 1ns/1ps
module power_loss_recovery_control
  import power_loss_pkg::*;
#(
  parameter longint unsigned WINDOW_CYCLES = power_loss_pkg::WINDOW_CYC,
  parameter int unsigned     FILTER_LEN    = power_loss_pkg::FILTER_CYC
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        standby_present,
  input  wire logic        supply_good_in,
  input  wire logic        operator_button_n,
  input  wire logic        sby_rail_fitted,
  output logic             supply_enable_n,
  output logic             irq,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import power_loss_pkg::*;

  // the filter counter is eight bits wide
  if (WINDOW_CYCLES < 2 || FILTER_LEN < 1 || FILTER_LEN > 255)
  begin : g_bad_params
    $error("power_loss_recovery_control: bad parameters");
  end

  ////////////////////////////////////////////////////////////////////////
  // standby filter
  logic       sby_meta_q;
  logic       sby_sync_q;
  logic       sby_filt_q;
  logic [7:0] filt_cnt_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sby_meta_q <= 1'b0;
      sby_sync_q <= 1'b0;
    end
    else if (clk_en)
    begin
      sby_meta_q <= standby_present;
      sby_sync_q <= sby_meta_q;
    end
  end

  // a glitch shorter than the filter never reaches the timer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sby_filt_q <= 1'b0;
      filt_cnt_q <= 8'h00;
    end
    else if (clk_en)
    begin
      if (sby_sync_q == sby_filt_q)
        filt_cnt_q <= 8'h00;
      else if (filt_cnt_q == 8'(FILTER_LEN - 1))
      begin
        sby_filt_q <= sby_sync_q;
        filt_cnt_q <= 8'h00;
      end
      else
        filt_cnt_q <= filt_cnt_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // button edge
  logic btn_q;
  logic btn_press;

  always_ff @(posedge clk)
  begin
    if (rst)
      btn_q <= 1'b1;
    else if (clk_en)
      btn_q <= operator_button_n;
  end

  assign btn_press = btn_q && !operator_button_n;

  ////////////////////////////////////////////////////////////////////////
  // retained settings; reset is only the host-side reset, a true loss
  // of all power is modelled by the standby input, so these survive it, except run_req_q, which is reloaded on restore from mode_q, last_on_q and sby_rail_fitted
  logic [1:0] mode_q;
  logic       run_req_q;
  logic       last_on_q;
  logic [EV_W-1:0] ev_q;
  logic [EV_W-1:0] mask_q;

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  pwr_state_e        st_q;
  logic [63:0]       win_cnt_q;
  logic              loss_flag_q;
  logic [EV_W-1:0]   ev_set;
  logic              mode_last;

  assign mode_last = (mode_q == 2'(MODE_LAST_STATE));

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q        <= PS_OFF;
      win_cnt_q   <= 64'h0;
      loss_flag_q <= 1'b0;
      last_on_q   <= 1'b0;
    end
    else if (clk_en)
    begin
      unique case (st_q)
        PS_ON:
        begin
          if (!sby_filt_q)
          begin
            st_q        <= PS_LOST;
            loss_flag_q <= 1'b1;
            last_on_q   <= 1'b1;
          end
          else if (!run_req_q)
          begin
            // last state may still read on until window passes
            st_q      <= mode_last ? PS_WATCH : PS_OFF;
            win_cnt_q <= 64'h0;
          end
        end
        PS_WATCH:
        begin
          if (!sby_filt_q)
          begin
            st_q        <= PS_LOST;
            loss_flag_q <= 1'b1;
          end
          else if (win_cnt_q == WINDOW_CYCLES - 1)
          begin
            st_q      <= PS_OFF;
            last_on_q <= 1'b0;
          end
          else
            win_cnt_q <= win_cnt_q + 64'h1;
          if (run_req_q && sby_filt_q)
            st_q <= PS_ON;
        end
        PS_OFF:
        begin
          if (!sby_filt_q)
          begin
            st_q        <= PS_LOST;
            loss_flag_q <= 1'b1;
          end
          else if (run_req_q)
          begin
            st_q      <= PS_ON;
            last_on_q <= 1'b1;
          end
        end
        PS_LOST:
        begin
          if (sby_filt_q)
          begin
            loss_flag_q <= 1'b0;
            if (!sby_rail_fitted)
              st_q <= PS_OFF;
            else if (mode_q == 2'(MODE_TURN_ON))
              st_q <= PS_ON;
            else if (mode_q == 2'(MODE_REMAIN_OFF))
              st_q <= PS_OFF;
            else
              st_q <= last_on_q ? PS_ON : PS_OFF;
          end
        end
      endcase
    end
  end

  // suspend output low means run
  always_ff @(posedge clk)
  begin
    if (rst)
      supply_enable_n <= 1'b1;
    else if (clk_en)
      supply_enable_n <= !(st_q == PS_ON && sby_filt_q);
  end

  always_comb
  begin
    ev_set = '0;
    if (clk_en && st_q == PS_WATCH && sby_filt_q && win_cnt_q == WINDOW_CYCLES - 1)
      ev_set[EV_ORDERLY] = 1'b1;
    if (clk_en && st_q != PS_LOST && !sby_filt_q)
      ev_set[EV_LOSS] = 1'b1;
    if (clk_en && st_q == PS_LOST && sby_filt_q)
      ev_set[EV_RESTORE] = 1'b1;
    if (clk_en && btn_press)
      ev_set[EV_BUTTON] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  logic        aw_q;
  logic        w_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        do_write;
  logic        wr_hit;

  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_q && w_q && !s_axi_bvalid;
  assign wr_hit        = awaddr_q == OFF_CTRL || awaddr_q == OFF_IRQ || awaddr_q == OFF_MASK;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      aw_q         <= 1'b0;
      w_q          <= 1'b0;
      awaddr_q     <= 8'h00;
      wdata_q      <= 32'h0;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q     <= 1'b1;
        awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_q         <= 1'b0;
        w_q          <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // control and mask registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_q    <= CTRL_RESET[CTRL_MODE_LSB +: 2];
      run_req_q <= CTRL_RESET[CTRL_RUN_BIT];
      mask_q    <= '0;
    end
    else if (clk_en)
    begin
      if (btn_press)
        run_req_q <= !run_req_q;
      if (st_q == PS_LOST && sby_filt_q)
        run_req_q <= sby_rail_fitted && (mode_q == 2'(MODE_TURN_ON) ||
                     (mode_q == 2'(MODE_LAST_STATE) && last_on_q));
      if (do_write && wstrb_q[0])
      begin
        if (awaddr_q == OFF_CTRL)
        begin
          // illegal mode code 3 ignored
          if (wdata_q[CTRL_MODE_LSB +: 2] != 2'b11)
            mode_q <= wdata_q[CTRL_MODE_LSB +: 2];
          run_req_q <= wdata_q[CTRL_RUN_BIT];
        end
        if (awaddr_q == OFF_MASK)
          mask_q <= wdata_q[EV_W-1:0];
      end
    end
  end

  // sticky events; a set in the clearing cycle wins
  always_ff @(posedge clk)
  begin
    if (rst)
      ev_q <= '0;
    else if (clk_en)
    begin
      if (do_write && wstrb_q[0] && awaddr_q == OFF_IRQ)
        ev_q <= (ev_q & ~wdata_q[EV_W-1:0]) | ev_set;
      else
        ev_q <= ev_q | ev_set;
    end
  end

  assign irq = |(ev_q & mask_q);

  // read side
  logic [31:0] rd_word;
  logic        rd_hit;

  always_comb
  begin
    rd_word = 32'h0;
    rd_hit  = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'b00})
      OFF_CTRL:
      begin
        rd_word[CTRL_MODE_LSB +: 2] = mode_q;
        rd_word[CTRL_RUN_BIT]       = run_req_q;
        rd_word[CTRL_LAST_BIT]      = last_on_q;
      end
      OFF_STATUS:
      begin
        rd_word[ST_SBY_BIT]  = sby_filt_q;
        rd_word[ST_GOOD_BIT] = supply_good_in;
        rd_word[ST_ON_BIT]   = !supply_enable_n;
        rd_word[ST_MON_BIT]  = st_q == PS_WATCH;
        rd_word[ST_LOSS_BIT] = loss_flag_q;
      end
      OFF_IRQ:  rd_word[EV_W-1:0] = ev_q;
      OFF_MASK: rd_word[EV_W-1:0] = mask_q;
      default:  rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule : power_loss_recovery_control

// *** tb/atx_supply_model.sv ***
// behavioural atx supply with standby rail
`timescale 1ns/1ps
module atx_supply_model (
  input  wire logic clk,
  input  wire logic ac_on,
  input  wire logic glitch,
  input  wire logic supply_enable_n,
  output logic      standby_present,
  output logic      supply_good_in
);
  logic [3:0] ramp_q = '0;
  // losing ac takes every rail, standby too
  assign standby_present = ac_on && !glitch;
  // main rails ramp only while enabled low
  always_ff @(posedge clk)
    if (!ac_on || supply_enable_n)
      ramp_q <= '0;
    else if (ramp_q != 4'hf)
      ramp_q <= ramp_q + 4'h1;
  // good held low until rails settled
  assign supply_good_in = (ramp_q >= 4'h8);
endmodule : atx_supply_model

// *** tb/power_loss_chk.sv ***
// assertions for the power loss controller
`timescale 1ns/1ps
module power_loss_chk
  import power_loss_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        standby_present,
  input wire logic        supply_enable_n,
  input wire logic        irq,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  rst_off_a: assert property (
    $fell(rst) |-> supply_enable_n && !irq) else $error("supply on after reset");
  loss_off_a: assert property (
    $fell(standby_present) ##1 !standby_present [*7] |-> ##[0:4] supply_enable_n)
    else $error("supply kept on after standby loss");
  // one cycle dip must not reach the timer
  glitch_on_a: assert property (
    !supply_enable_n && $fell(standby_present) ##1 standby_present |=> !supply_enable_n [*8])
    else $error("glitch switched supply off");
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  w_refuse_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken during response");
  r_refuse_a: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken during response");
  b_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("no write response");
  r_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid) else $error("no read response");
  cover property ($rose(standby_present) ##[1:20] $fell(supply_enable_n));
  cover property ($rose(irq));
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : power_loss_chk
bind power_loss_recovery_control power_loss_chk chk_u (.*);

// *** tb/testbench.sv ***
// testbench for the power loss controller
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module testbench;
  import power_loss_pkg::*;
  localparam int W = 200;
  logic        clk = 0, rst = 1, clk_en = 1, sby_rail_fitted = 1, operator_button_n = 1;
  logic        ac_on = 1, glitch = 0, standby_present, supply_good_in, supply_enable_n, irq;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  int          err_count = 0, num_checks = 0;
  always #4 clk = ~clk;
  power_loss_recovery_control #(.WINDOW_CYCLES(W), .FILTER_LEN(4)) dut_u (.*);
  atx_supply_model sup_u (.*);
  ////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, ra, rw;
    ta = 0;
    tw = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(ta && tw))
    begin
      @(negedge clk);
      ra = s_axi_awready;
      rw = s_axi_wready;
      @(posedge clk);
      if (ra) s_axi_awvalid <= 0;
      if (rw) s_axi_wvalid <= 0;
      ta |= ra;
      tw |= rw;
    end
    do
    begin
      @(negedge clk);
      rs = s_axi_bresp;
      ra = s_axi_bvalid;
      @(posedge clk);
    end while (!ra);
    s_axi_bready <= 0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    logic ok;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do
    begin
      @(negedge clk);
      ok = s_axi_arready;
      @(posedge clk);
    end while (!ok);
    s_axi_arvalid <= 0;
    do
    begin
      @(negedge clk);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      ok = s_axi_rvalid;
      @(posedge clk);
    end while (!ok);
    s_axi_rready <= 0;
  endtask : rdr
  // ac off long enough to pass the filter, then back
  task automatic ac_cycle;
    @(posedge clk);
    ac_on <= 0;
    cyc(30);
    ac_on <= 1;
    cyc(40);
  endtask : ac_cycle
  task automatic press;
    operator_button_n <= 0;
    cyc(4);
    operator_button_n <= 1;
    cyc(20);
  endtask : press
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdr(OFF_CTRL);
    `CHK("ctrl", CTRL_RESET, rd)
    cyc(40);
    `CHK("supply_enable_n", 1'b0, supply_enable_n)
    rdr(OFF_STATUS);
    `CHK("status", 3'h7, rd[2:0])
    rdr(8'h10);
    `CHK("rresp", RESP_SLVERR, rs)
    `CHK("rdata", 32'h0, rd)
    wr(8'h10, 32'h0);
    `CHK("bresp", RESP_SLVERR, rs)
    $display("test reset done");
  endtask : t_reset
  task automatic t_turn_on;
    wr(OFF_IRQ, 32'hf);
    ac_cycle;
    `CHK("supply_enable_n", 1'b0, supply_enable_n)
    rdr(OFF_IRQ);
    `CHK("events", 32'h6, rd)
    `CHK("irq", 1'b0, irq)
    wr(OFF_MASK, 32'h2);
    `CHK("irq", 1'b1, irq)
    wr(OFF_IRQ, 32'h6);
    `CHK("irq", 1'b0, irq)
    wr(OFF_CTRL, 32'h0);
    cyc(5);
    `CHK("supply_enable_n", 1'b1, supply_enable_n)
    rdr(OFF_STATUS);
    `CHK("window", 1'b0, rd[ST_MON_BIT])
    press;
    `CHK("supply_enable_n", 1'b0, supply_enable_n)
    $display("test turn on done");
  endtask : t_turn_on
  task automatic t_last;
    @(posedge clk);
    glitch <= 1;
    @(posedge clk);
    glitch <= 0;
    cyc(20);
    `CHK("supply_enable_n", 1'b0, supply_enable_n)
    wr(OFF_CTRL, 32'h6);
    ac_cycle;
    `CHK("supply_enable_n", 1'b0, supply_enable_n)
    wr(OFF_CTRL, 32'h2);
    cyc(5);
    rdr(OFF_STATUS);
    `CHK("window", 1'b1, rd[ST_MON_BIT])
    cyc(W);
    rdr(OFF_IRQ);
    `CHK("orderly", 1'b1, rd[EV_ORDERLY])
    rdr(OFF_CTRL);
    `CHK("last_on", 1'b0, rd[CTRL_LAST_BIT])
    ac_cycle;
    `CHK("supply_enable_n", 1'b1, supply_enable_n)
    $display("test last state done");
  endtask : t_last
  task automatic t_window_loss;
    press;
    wr(OFF_CTRL, 32'h2);
    cyc(20);
    ac_cycle;
    `CHK("supply_enable_n", 1'b0, supply_enable_n)
    wr(OFF_CTRL, 32'h5);
    ac_cycle;
    `CHK("supply_enable_n", 1'b1, supply_enable_n)
    rdr(OFF_CTRL);
    `CHK("mode", 2'h1, rd[1:0])
    $display("test window loss done");
  endtask : t_window_loss
  task automatic t_no_rail;
    @(posedge clk);
    sby_rail_fitted <= 0;
    wr(OFF_CTRL, 32'h4);
    ac_cycle;
    `CHK("supply_enable_n", 1'b1, supply_enable_n)
    $display("test no rail done");
  endtask : t_no_rail
  // a press while frozen must be lost; mode code 3 is refused
  task automatic t_freeze;
    @(posedge clk);
    clk_en <= 0;
    press;
    clk_en <= 1;
    cyc(10);
    `CHK("supply_enable_n", 1'b1, supply_enable_n)
    wr(OFF_CTRL, 32'h7);
    rdr(OFF_CTRL);
    `CHK("mode", 2'h0, rd[1:0])
    $display("test freeze done");
  endtask : t_freeze
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  initial
  begin
    cyc(3);
    rst <= 0;
    t_reset;
    t_turn_on;
    t_last;
    t_window_loss;
    t_no_rail;
    t_freeze;
    summarize;
  end
  initial
  begin
    cyc(6000);
    err_count++;
    summarize;
  end
endmodule : testbench
